// ### verilog/scan_port_pkg.sv
package scan_port_pkg;

  // ****************************************
  // Scan path lengths
  // ****************************************
  localparam int INSTR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int CHAIN_LEN = 109;
  localparam int PIN_CELLS = 108;
  localparam int GATE_CELL = 108;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_IDCODE = 3'h1;
  localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [2:0] OP_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE_PATTERN = 3'h1;

  // ****************************************
  // Identification word fields (values arbitrary)
  // ****************************************
  localparam logic [2:0] ID_REVISION = 3'h1;
  localparam logic [16:0] ID_PART = 17'h0a5a5;
  localparam logic [10:0] ID_VENDOR = 11'h155;
  localparam logic ID_PRESENT = 1'h1;

  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR,
    EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_e;

  // Serial pins as sampled
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } scan_pins_s;

endpackage

// ### verilog/pin_sync.sv
module pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Raw pins
  input wire scan_port_pkg::scan_pins_s raw,
  // Filtered pins
  output scan_port_pkg::scan_pins_s clean
);

  // ****************************************
  // Three stages, change accepted when last two agree
  // ****************************************
  scan_port_pkg::scan_pins_s stage1, stage2, stage3, held;
  scan_port_pkg::scan_pins_s next_held;

  always_comb
  begin
    next_held = held;
    // Each pin settles on its own
    for (int i = 0; i < $bits(held); i++)
    begin
      if (stage2[i] == stage3[i])
      begin
        next_held[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      held <= '0;
    end
    else
    begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      held <= next_held;
    end
  end

  assign clean = held;

endmodule

// ### verilog/sram_boundary_scan_tap.sv
// Contract
// R1 - Mode select and serial input are sampled on test clock rising edge.
// R2 - Serial output changes after test clock falling edge.
// R3 - Paths: instruction 3, bypass 1, identification 32, boundary 109 bits.
// R4 - Code 000 captures ring into boundary chain and connects it.
// R5 - Code 001 loads identification word and connects it; memory unaffected.
// R6 - Code 010 captures pins, connects chain, tristates all outputs.
// R7 - Code 100 captures pins, connects chain; memory unaffected.
// R8 - Code 111 connects the one-bit bypass; memory unaffected.
// R9 - Controller never loads codes 011, 101, 110; here Update-IR loads any code, and these three select the bypass.
// R10 - Identification: revision 31:29, part 28:12, vendor 11:1.
// R11 - Identification bit 0 always reads one.
// R12 - Cells 0..107 map to package positions; cell 108 is internal.
// R13 - Cell 108 gates output bus under code 000; presets high.
// R14 - Code 001 becomes current at reset and in test-logic-reset.
// R15 - Instruction shifts in Shift-IR, takes effect at Update-IR.
// R16 - Controller follows the sixteen-state machine on rising test clock.
module sram_boundary_scan_tap (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // Package positions, cells 0..107
  input wire logic [scan_port_pkg::PIN_CELLS-1:0] package_position,
  // Boundary update register and controls toward the pad ring
  output logic [scan_port_pkg::CHAIN_LEN-1:0] boundary_preload,
  output logic extest_active,
  output logic output_bus_enable,
  // Current instruction
  output logic [scan_port_pkg::INSTR_LEN-1:0] current_instruction
);

  // ****************************************
  // Pin sampling and edge detect
  // ****************************************
  scan_port_pkg::scan_pins_s raw_pins, pins;
  logic tck_last;
  logic next_tck_last;
  logic tck_rise, tck_fall;

  assign raw_pins = '{tck: tck, tms: tms, tdi: tdi};

  pin_sync u_pin_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .raw(raw_pins),
    .clean(pins)
  );

  assign next_tck_last = pins.tck;
  assign tck_rise = pins.tck && !tck_last; // [R1]
  assign tck_fall = !pins.tck && tck_last; // [R2]

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      tck_last <= 1'b0;
    end
    else
    begin
      tck_last <= next_tck_last;
    end
  end

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic uses_chain(input logic [2:0] op);
    uses_chain = (op == scan_port_pkg::OP_EXTEST) || (op == scan_port_pkg::OP_SAMPLE_Z)
      || (op == scan_port_pkg::OP_SAMPLE_PRELOAD); // [R4] [R6] [R7]
  endfunction

  function automatic logic uses_id(input logic [2:0] op);
    uses_id = (op == scan_port_pkg::OP_IDCODE); // [R5]
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  scan_port_pkg::tap_state_e state, next_state;
  logic [scan_port_pkg::INSTR_LEN-1:0] ir_shift, next_ir_shift; // [R3]
  logic [scan_port_pkg::INSTR_LEN-1:0] ir_cur, next_ir_cur;
  logic bypass_cell, next_bypass_cell; // [R3]
  logic [scan_port_pkg::ID_LEN-1:0] id_shift, next_id_shift; // [R3]
  logic [scan_port_pkg::CHAIN_LEN-1:0] chain, next_chain; // [R3]
  logic [scan_port_pkg::CHAIN_LEN-1:0] preload, next_preload;
  logic tdo_q, next_tdo_q;
  logic oe_n_q, next_oe_n_q;
  logic [scan_port_pkg::ID_LEN-1:0] id_word;

  assign id_word = {scan_port_pkg::ID_REVISION, scan_port_pkg::ID_PART,
    scan_port_pkg::ID_VENDOR, scan_port_pkg::ID_PRESENT}; // [R10] [R11]

  // ****************************************
  // State machine
  // ****************************************
  always_comb
  begin
    next_state = state;
    if (tck_rise)
    begin
      unique case (state) // [R16]
        scan_port_pkg::TEST_LOGIC_RESET:
          next_state = pins.tms ? scan_port_pkg::TEST_LOGIC_RESET : scan_port_pkg::RUN_IDLE;
        scan_port_pkg::RUN_IDLE:
          next_state = pins.tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_IDLE;
        scan_port_pkg::SELECT_DR:
          next_state = pins.tms ? scan_port_pkg::SELECT_IR : scan_port_pkg::CAPTURE_DR;
        scan_port_pkg::CAPTURE_DR:
          next_state = pins.tms ? scan_port_pkg::EXIT1_DR : scan_port_pkg::SHIFT_DR;
        scan_port_pkg::SHIFT_DR:
          next_state = pins.tms ? scan_port_pkg::EXIT1_DR : scan_port_pkg::SHIFT_DR;
        scan_port_pkg::EXIT1_DR:
          next_state = pins.tms ? scan_port_pkg::UPDATE_DR : scan_port_pkg::PAUSE_DR;
        scan_port_pkg::PAUSE_DR:
          next_state = pins.tms ? scan_port_pkg::EXIT2_DR : scan_port_pkg::PAUSE_DR;
        scan_port_pkg::EXIT2_DR:
          next_state = pins.tms ? scan_port_pkg::UPDATE_DR : scan_port_pkg::SHIFT_DR;
        scan_port_pkg::UPDATE_DR:
          next_state = pins.tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_IDLE;
        scan_port_pkg::SELECT_IR:
          next_state = pins.tms ? scan_port_pkg::TEST_LOGIC_RESET : scan_port_pkg::CAPTURE_IR;
        scan_port_pkg::CAPTURE_IR:
          next_state = pins.tms ? scan_port_pkg::EXIT1_IR : scan_port_pkg::SHIFT_IR;
        scan_port_pkg::SHIFT_IR:
          next_state = pins.tms ? scan_port_pkg::EXIT1_IR : scan_port_pkg::SHIFT_IR;
        scan_port_pkg::EXIT1_IR:
          next_state = pins.tms ? scan_port_pkg::UPDATE_IR : scan_port_pkg::PAUSE_IR;
        scan_port_pkg::PAUSE_IR:
          next_state = pins.tms ? scan_port_pkg::EXIT2_IR : scan_port_pkg::PAUSE_IR;
        scan_port_pkg::EXIT2_IR:
          next_state = pins.tms ? scan_port_pkg::UPDATE_IR : scan_port_pkg::SHIFT_IR;
        scan_port_pkg::UPDATE_IR:
          next_state = pins.tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state <= scan_port_pkg::TEST_LOGIC_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************
  // Scan paths capture and shift on rising test clock, update on falling
  // ****************************************
  always_comb
  begin
    next_ir_shift = ir_shift;
    next_ir_cur = ir_cur;
    next_bypass_cell = bypass_cell;
    next_id_shift = id_shift;
    next_chain = chain;
    next_preload = preload;
    if (state == scan_port_pkg::TEST_LOGIC_RESET)
    begin
      next_ir_cur = scan_port_pkg::OP_IDCODE; // [R14]
      next_preload[scan_port_pkg::GATE_CELL] = 1'b1; // [R13]
    end
    if (tck_rise)
    begin
      unique case (state)
        scan_port_pkg::CAPTURE_IR:
          next_ir_shift = scan_port_pkg::IR_CAPTURE_PATTERN;
        scan_port_pkg::SHIFT_IR:
          next_ir_shift = {pins.tdi, ir_shift[scan_port_pkg::INSTR_LEN-1:1]}; // [R15]
        scan_port_pkg::CAPTURE_DR:
        begin
          next_bypass_cell = 1'b0;
          if (uses_id(ir_cur))
          begin
            next_id_shift = id_word; // [R5]
          end
          if (uses_chain(ir_cur))
          begin
            // Pin cells from package, internal cell keeps its update value
            next_chain = {preload[scan_port_pkg::GATE_CELL], package_position}; // [R12]
          end
        end
        scan_port_pkg::SHIFT_DR:
        begin
          if (uses_id(ir_cur))
          begin
            next_id_shift = {pins.tdi, id_shift[scan_port_pkg::ID_LEN-1:1]};
          end
          else if (uses_chain(ir_cur))
          begin
            // Input at the top cell, output from cell 0
            next_chain = {pins.tdi, chain[scan_port_pkg::CHAIN_LEN-1:1]};
          end
          else
          begin
            next_bypass_cell = pins.tdi; // [R8]
          end
        end
        default:
        begin
        end
      endcase
    end
    if (tck_fall)
    begin
      if (state == scan_port_pkg::UPDATE_IR)
      begin
        next_ir_cur = ir_shift; // [R15]
      end
      if (state == scan_port_pkg::UPDATE_DR && uses_chain(ir_cur))
      begin
        next_preload = chain; // [R13]
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ir_shift <= scan_port_pkg::OP_IDCODE;
      ir_cur <= scan_port_pkg::OP_IDCODE; // [R14]
      bypass_cell <= 1'b0;
      id_shift <= '0;
      chain <= '0;
      preload <= {1'b1, {scan_port_pkg::PIN_CELLS{1'b0}}}; // [R13]
    end
    else
    begin
      ir_shift <= next_ir_shift;
      ir_cur <= next_ir_cur;
      bypass_cell <= next_bypass_cell;
      id_shift <= next_id_shift;
      chain <= next_chain;
      preload <= next_preload;
    end
  end

  // ****************************************
  // Serial output on falling test clock
  // ****************************************
  always_comb
  begin
    next_tdo_q = tdo_q;
    next_oe_n_q = oe_n_q;
    if (tck_fall) // [R2]
    begin
      next_oe_n_q = !(state == scan_port_pkg::SHIFT_DR || state == scan_port_pkg::SHIFT_IR);
      if (state == scan_port_pkg::SHIFT_IR)
      begin
        next_tdo_q = ir_shift[0];
      end
      else if (uses_id(ir_cur))
      begin
        next_tdo_q = id_shift[0];
      end
      else if (uses_chain(ir_cur))
      begin
        next_tdo_q = chain[0];
      end
      else
      begin
        next_tdo_q = bypass_cell;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      tdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      tdo_q <= next_tdo_q;
      oe_n_q <= next_oe_n_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tdo = tdo_q;
  assign tdo_oe_n = oe_n_q;
  assign boundary_preload = preload;
  assign current_instruction = ir_cur;
  assign extest_active = (ir_cur == scan_port_pkg::OP_EXTEST);
  // Data bus drive: off under 010, gated by cell 108 under 000
  assign output_bus_enable = !(ir_cur == scan_port_pkg::OP_SAMPLE_Z)
    && !(extest_active && !preload[scan_port_pkg::GATE_CELL]); // [R6] [R13]

endmodule

// ### verif/scan_port_properties.sv
module scan_port_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  // Pad ring side
  input wire logic [scan_port_pkg::PIN_CELLS-1:0] package_position,
  input wire logic [scan_port_pkg::CHAIN_LEN-1:0] boundary_preload,
  input wire logic extest_active,
  input wire logic output_bus_enable,
  input wire logic [scan_port_pkg::INSTR_LEN-1:0] current_instruction
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Port timing and instruction effects
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence sel_tristate;
    $changed(current_instruction) ##0 current_instruction == scan_port_pkg::OP_SAMPLE_Z;
  endsequence
  reset_instr_a: assert property ($rose(nrst) |-> current_instruction == 3'h1)
    else $error("instruction not identify after reset");
  reset_gate_a: assert property ($rose(nrst) |-> boundary_preload[108])
    else $error("gate cell not preset");
  extest_flag_a: assert property (extest_active == (current_instruction == 3'h0))
    else $error("extest flag wrong");
  bus_enable_a: assert property (output_bus_enable ==
    !(current_instruction == 3'h2 || (extest_active && !boundary_preload[108])))
    else $error("output bus enable wrong");
  tdo_fall_a: assert property ($changed(tdo) |-> !tck && $past(tck, 8))
    else $error("serial out moved off falling edge");
  oe_fall_a: assert property ($changed(tdo_oe_n) |-> !tck && $past(tck, 8))
    else $error("serial enable moved off falling edge");
  instr_update_a: assert property ($changed(current_instruction) &&
    current_instruction != 3'h1 |-> !tck)
    else $error("instruction changed while test clock high");
  preload_update_a: assert property ($changed(boundary_preload[107:0]) |->
    !tck && current_instruction inside {3'h0, 3'h2, 3'h4})
    else $error("preload changed outside update");
  tristate_hold_a: assert property (sel_tristate |-> (!output_bus_enable)[*8])
    else $error("bus not tristated");
endmodule

// ### verif/scan_controller.sv
module scan_controller (
  // Clock
  input wire logic ref_clk,
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  logic q;
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One test clock period, out bit taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    wait_clk(1);
    tms = m;
    tdi = d;
    wait_clk(8);
    o = tdo;
    tck = 1'h1;
    wait_clk(15);
    tck = 1'h0;
    tdi = ~d;
    wait_clk(7);
  endtask
  task automatic reset_tap();
    repeat (5) step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
  // Only defined codes are ever loaded
  task automatic load_ir(input logic [2:0] code);
    step(1'h1, 1'h0, q);
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < 3; i++) step(i == 2, code[i], q);
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
  task automatic scan_dr(input int n, input logic [108:0] din, output logic [108:0] dout);
    dout = 109'h0;
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
endmodule

// ### verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic tck, tms, tdi, tdo, tdo_oe_n, extest_active, output_bus_enable;
  logic [107:0] pins = {{25{4'h9}}, 8'h3c};
  logic [108:0] preload, dout;
  logic [2:0] instr;
  logic bit_out;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  sram_boundary_scan_tap u_dut (.ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .package_position(pins),
    .boundary_preload(preload), .extest_active(extest_active),
    .output_bus_enable(output_bus_enable), .current_instruction(instr));
  scan_controller u_ctrl (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // ****************************************
  // Checks and closing
  // ****************************************
  task automatic check(input logic [108:0] got, input logic [108:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1 nrst = 1'h1;
    u_ctrl.reset_tap();
    check(instr, scan_port_pkg::OP_IDCODE, "reset instruction");
    check(preload, {1'h1, 108'h0}, "reset preload");
    u_ctrl.scan_dr(33, 109'h1, dout);
    check(dout[32:0], {1'h1, scan_port_pkg::ID_REVISION, scan_port_pkg::ID_PART,
      scan_port_pkg::ID_VENDOR, 1'h1}, "identification word");
    u_ctrl.step(1'h1, 1'h0, bit_out);
    u_ctrl.step(1'h0, 1'h0, bit_out);
    u_ctrl.step(1'h0, 1'h0, bit_out);
    check({tdo_oe_n, tdo}, 2'h1, "serial out driven in shift");
    u_ctrl.step(1'h1, 1'h0, bit_out);
    u_ctrl.step(1'h1, 1'h0, bit_out);
    u_ctrl.step(1'h0, 1'h0, bit_out);
    check(tdo_oe_n, 1'h1, "serial out released");
    u_ctrl.load_ir(scan_port_pkg::OP_BYPASS);
    u_ctrl.scan_dr(2, 109'h1, dout);
    check({instr, dout[1], output_bus_enable}, {3'h7, 2'h3}, "bypass path");
    u_ctrl.load_ir(scan_port_pkg::OP_SAMPLE_PRELOAD);
    u_ctrl.scan_dr(109, {1'h0, ~pins}, dout);
    check(dout, {1'h1, pins}, "sampled pins");
    check(preload, {1'h0, ~pins}, "preload update");
    check(output_bus_enable, 1'h1, "bus enabled");
    u_ctrl.load_ir(scan_port_pkg::OP_EXTEST);
    check({extest_active, output_bus_enable}, 2'h2, "gated bus");
    u_ctrl.scan_dr(109, {1'h1, pins}, dout);
    check(dout, {1'h0, pins}, "ring capture");
    check(output_bus_enable, 1'h1, "gate cell high");
    u_ctrl.load_ir(scan_port_pkg::OP_SAMPLE_Z);
    check({extest_active, output_bus_enable}, 2'h0, "tristated bus");
    u_ctrl.scan_dr(109, {1'h0, ~pins}, dout);
    check(dout, {1'h1, pins}, "tristate chain capture");
    check({preload, output_bus_enable}, {1'h0, ~pins, 1'h0}, "tristate preload");
    u_ctrl.reset_tap();
    check({instr, preload[108], output_bus_enable}, 5'h7, "reset state");
    stop_test();
  end
endmodule
bind sram_boundary_scan_tap scan_port_properties u_props (.ref_clk(ref_clk), .nrst(nrst),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .package_position(package_position), .boundary_preload(boundary_preload),
  .extest_active(extest_active), .output_bus_enable(output_bus_enable),
  .current_instruction(current_instruction));
